// >>> verilog/halfword_mul_nmac_pkg.sv
// constants, types and register map of the halfword multiply / negative mac unit
// assumes an apb master on pclk; bit positions below are little-endian indices
//
// What this block does
// - modulo nmac: acc minus low product, low 32
// - saturating nmac: clamp overflowing difference, else low 32
// - basic nmac leaves exception reg and condition field alone
// - record forms update condition field from written result
// - overflow-enabled nmac updates overflow and summary flags
// - overflow-enabled record nmac updates both flags and condition
// - cross multiply: first low half times second high
// - signed cross multiply uses two's-complement halves
// - unsigned cross multiply uses unsigned halves
// - cross multiply never touches exception register
// - condition update chosen per opcode, else untouched
package halfword_mul_nmac_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] src_a_off  = 8'h04;
  localparam logic [7:0] src_b_off  = 8'h08;
  localparam logic [7:0] acc_off    = 8'h0c;
  localparam logic [7:0] excp_off   = 8'h10;
  localparam logic [7:0] cr_off     = 8'h14;
  localparam logic [7:0] status_off = 8'h18;

  // ctrl fields
  localparam int ctrl_kind_lsb   = 0;
  localparam int ctrl_record_bit = 2;
  localparam int ctrl_oe_bit     = 3;

  // exception register fields (big-endian bit 0 = summary, bit 1 = overflow)
  localparam int excp_so_bit = 31;
  localparam int excp_ov_bit = 30;

  // condition field zero layout
  localparam int cr_lt_bit = 3;
  localparam int cr_gt_bit = 2;
  localparam int cr_eq_bit = 1;
  localparam int cr_so_bit = 0;

  // status fields
  localparam int status_busy_bit = 0;
  localparam int status_ovf_bit  = 1;
  localparam int status_sat_bit  = 2;
  localparam int status_cnt_lsb  = 8;

  // reset values and clamp limits
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [3:0]  cr_reset   = 4'h0;
  localparam logic [7:0]  cnt_reset  = 8'h00;
  localparam logic [31:0] sat_max    = 32'h7fff_ffff;
  localparam logic [31:0] sat_min    = 32'h8000_0000;

  typedef enum logic [1:0] {
    op_nmac_modulo        = 2'b00,
    op_nmac_saturate      = 2'b01,
    op_mul_cross_signed   = 2'b10,
    op_mul_cross_unsigned = 2'b11
  } op_kind_t;

  typedef enum logic {
    st_idle = 1'b0,
    st_exec = 1'b1
  } exec_state_t;

endpackage

// >>> verilog/halfword_multiplier.sv
// 16 x 16 multiplier with signed or unsigned operands, 32-bit product
// assumes operands are stable for the cycle; purely combinational
`timescale 1ns/1ps
module halfword_multiplier (
  input  wire logic [15:0] mul_a,
  input  wire logic [15:0] mul_b,
  input  wire logic        mul_signed,
  output logic      [31:0] mul_product
);

  logic [16:0] ext_a;
  logic [16:0] ext_b;
  logic [33:0] wide;

  always_comb begin
    ext_a       = {mul_signed & mul_a[15], mul_a};
    ext_b       = {mul_signed & mul_b[15], mul_b};
    wide        = 34'($signed(ext_a) * $signed(ext_b));
    mul_product = wide[31:0];
  end

endmodule

// >>> verilog/cr0_compute.sv
// derives condition field zero from a result word and the summary-overflow bit
// assumes the result is a signed 32-bit value; purely combinational
`timescale 1ns/1ps
module cond_field_compute (
  input  wire logic [31:0] result,
  input  wire logic        summary_ovf,
  output logic      [3:0]  cr_field
);

  always_comb begin
    cr_field = halfword_mul_nmac_pkg::cr_reset;
    cr_field[halfword_mul_nmac_pkg::cr_lt_bit] = result[31];
    cr_field[halfword_mul_nmac_pkg::cr_gt_bit] = ~result[31] & (result != 32'h0000_0000);
    cr_field[halfword_mul_nmac_pkg::cr_eq_bit] = (result == 32'h0000_0000);
    cr_field[halfword_mul_nmac_pkg::cr_so_bit] = summary_ovf;
  end

endmodule

// >>> verilog/halfword_mul_nmac_unit.sv
// apb-mapped datapath for negative mac low-halfword and cross-halfword multiply
// assumes a single pclk domain and an apb master that holds each request
`timescale 1ns/1ps
module halfword_mul_nmac_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  halfword_mul_nmac_pkg::exec_state_t state;
  halfword_mul_nmac_pkg::exec_state_t next_state;
  halfword_mul_nmac_pkg::op_kind_t    op_kind;
  halfword_mul_nmac_pkg::op_kind_t    next_op_kind;

  logic        op_record;
  logic        next_op_record;
  logic        op_oe;
  logic        next_op_oe;
  logic [31:0] first_source_operand;
  logic [31:0] next_first_source_operand;
  logic [31:0] second_source_operand;
  logic [31:0] next_second_source_operand;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] fixed_point_exception_reg;
  logic [31:0] next_fixed_point_exception_reg;
  logic [3:0]  condition_field_zero;
  logic [3:0]  next_condition_field_zero;
  logic [7:0]  op_count;
  logic [7:0]  next_op_count;
  logic        last_ovf;
  logic        next_last_ovf;
  logic        last_sat;
  logic        next_last_sat;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  logic        is_nmac;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic        mul_signed;
  logic [31:0] product;
  logic [32:0] diff;
  logic        ovf;
  logic [31:0] result;
  logic        new_so;
  logic        upd_excp;
  logic [3:0]  cr_new;

  always_comb begin
    is_nmac = (op_kind == halfword_mul_nmac_pkg::op_nmac_modulo) ||
              (op_kind == halfword_mul_nmac_pkg::op_nmac_saturate);
    // big-endian bits 16:31 are the low halfword, bits 0:15 the high one
    mul_a = first_source_operand[15:0];
    if (is_nmac) begin
      mul_b      = second_source_operand[15:0];
      mul_signed = 1'b1;
    end else begin
      mul_b      = second_source_operand[31:16];
      mul_signed = (op_kind == halfword_mul_nmac_pkg::op_mul_cross_signed);
    end
  end

  halfword_multiplier u_mul (
    .mul_a       (mul_a),
    .mul_b       (mul_b),
    .mul_signed  (mul_signed),
    .mul_product (product)
  );

  always_comb begin
    // 33-bit intermediate, product is signed for the nmac group
    diff = {acc[31], acc} - {product[31], product};
    ovf  = is_nmac & (diff[32] ^ diff[31]);
    case (op_kind)
      halfword_mul_nmac_pkg::op_nmac_modulo: begin
        result = diff[31:0];
      end
      halfword_mul_nmac_pkg::op_nmac_saturate: begin
        if (ovf) begin
          // sign of the true difference picks the clamp direction
          result = diff[32] ? halfword_mul_nmac_pkg::sat_min
                            : halfword_mul_nmac_pkg::sat_max;
        end else begin
          result = diff[31:0];
        end
      end
      default: begin
        result = product;
      end
    endcase
    upd_excp = is_nmac & op_oe;
    new_so   = fixed_point_exception_reg[halfword_mul_nmac_pkg::excp_so_bit] | (upd_excp & ovf);
  end

  // summary overflow seen by the condition field is the value after this instruction
  cond_field_compute u_cond (
    .result      (result),
    .summary_ovf (new_so),
    .cr_field    (cr_new)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        access;
  logic        busy;
  logic        write_ok;
  logic [31:0] rd_word;
  logic        mapped;

  always_comb begin
    access = psel & penable & ~pready;
    busy   = (state == halfword_mul_nmac_pkg::st_exec);

    // read decode
    mapped  = 1'b1;
    rd_word = halfword_mul_nmac_pkg::word_reset;
    if (paddr == halfword_mul_nmac_pkg::ctrl_off) begin
      rd_word[halfword_mul_nmac_pkg::ctrl_kind_lsb +: 2] = op_kind;
      rd_word[halfword_mul_nmac_pkg::ctrl_record_bit]    = op_record;
      rd_word[halfword_mul_nmac_pkg::ctrl_oe_bit]        = op_oe;
    end else if (paddr == halfword_mul_nmac_pkg::src_a_off) begin
      rd_word = first_source_operand;
    end else if (paddr == halfword_mul_nmac_pkg::src_b_off) begin
      rd_word = second_source_operand;
    end else if (paddr == halfword_mul_nmac_pkg::acc_off) begin
      rd_word = acc;
    end else if (paddr == halfword_mul_nmac_pkg::excp_off) begin
      rd_word = fixed_point_exception_reg;
    end else if (paddr == halfword_mul_nmac_pkg::cr_off) begin
      rd_word[3:0] = condition_field_zero;
    end else if (paddr == halfword_mul_nmac_pkg::status_off) begin
      rd_word[halfword_mul_nmac_pkg::status_busy_bit]   = busy;
      rd_word[halfword_mul_nmac_pkg::status_ovf_bit]    = last_ovf;
      rd_word[halfword_mul_nmac_pkg::status_sat_bit]    = last_sat;
      rd_word[halfword_mul_nmac_pkg::status_cnt_lsb +: 8] = op_count;
    end else begin
      mapped = 1'b0;
    end

    // writes during execution would race the write-back, so refuse them
    write_ok = access & pwrite & mapped & ~busy &
               (paddr != halfword_mul_nmac_pkg::status_off);
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation select: a ctrl write latches the opcode and starts one execute cycle

  always_comb begin
    next_state     = state;
    next_op_kind   = op_kind;
    next_op_record = op_record;
    next_op_oe     = op_oe;
    case (state)
      halfword_mul_nmac_pkg::st_idle: begin
        if (write_ok && paddr == halfword_mul_nmac_pkg::ctrl_off) begin
          next_op_kind   = halfword_mul_nmac_pkg::op_kind_t'(
                             pwdata[halfword_mul_nmac_pkg::ctrl_kind_lsb +: 2]);
          next_op_record = pwdata[halfword_mul_nmac_pkg::ctrl_record_bit];
          next_op_oe     = pwdata[halfword_mul_nmac_pkg::ctrl_oe_bit];
          next_state     = halfword_mul_nmac_pkg::st_exec;
        end
      end
      default: begin
        // execute lasts exactly one cycle
        next_state = halfword_mul_nmac_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= halfword_mul_nmac_pkg::st_idle;
      op_kind   <= halfword_mul_nmac_pkg::op_nmac_modulo;
      op_record <= 1'b0;
      op_oe     <= 1'b0;
    end else begin
      state     <= next_state;
      op_kind   <= next_op_kind;
      op_record <= next_op_record;
      op_oe     <= next_op_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architected registers: operands, accumulator, exception register, condition field

  always_comb begin
    next_first_source_operand      = first_source_operand;
    next_second_source_operand     = second_source_operand;
    next_acc                       = acc;
    next_fixed_point_exception_reg = fixed_point_exception_reg;
    next_condition_field_zero      = condition_field_zero;

    // write-back of the operation, one cycle after the ctrl write
    if (busy) begin
      next_acc = result;
      if (upd_excp) begin
        next_fixed_point_exception_reg[halfword_mul_nmac_pkg::excp_ov_bit] = ovf;
        next_fixed_point_exception_reg[halfword_mul_nmac_pkg::excp_so_bit] = new_so;
      end
      if (op_record) begin
        next_condition_field_zero = cr_new;
      end
      // without oe and record both registers keep their values
    end

    // software writes; write_ok is never true in a write-back cycle
    if (write_ok) begin
      if (paddr == halfword_mul_nmac_pkg::src_a_off) begin
        next_first_source_operand = pwdata;
      end else if (paddr == halfword_mul_nmac_pkg::src_b_off) begin
        next_second_source_operand = pwdata;
      end else if (paddr == halfword_mul_nmac_pkg::acc_off) begin
        next_acc = pwdata;
      end else if (paddr == halfword_mul_nmac_pkg::excp_off) begin
        next_fixed_point_exception_reg = pwdata;
      end else if (paddr == halfword_mul_nmac_pkg::cr_off) begin
        next_condition_field_zero = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_source_operand      <= halfword_mul_nmac_pkg::word_reset;
      second_source_operand     <= halfword_mul_nmac_pkg::word_reset;
      acc                       <= halfword_mul_nmac_pkg::word_reset;
      fixed_point_exception_reg <= halfword_mul_nmac_pkg::word_reset;
      condition_field_zero      <= halfword_mul_nmac_pkg::cr_reset;
    end else begin
      first_source_operand      <= next_first_source_operand;
      second_source_operand     <= next_second_source_operand;
      acc                       <= next_acc;
      fixed_point_exception_reg <= next_fixed_point_exception_reg;
      condition_field_zero      <= next_condition_field_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: completion count and flags of the last operation

  always_comb begin
    next_op_count = op_count;
    next_last_ovf = last_ovf;
    next_last_sat = last_sat;
    if (busy) begin
      // the count wraps, so software compares two reads to see progress
      next_op_count = op_count + 8'h01;
      next_last_ovf = ovf;
      next_last_sat = ovf & (op_kind == halfword_mul_nmac_pkg::op_nmac_saturate);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_count <= halfword_mul_nmac_pkg::cnt_reset;
      last_ovf <= 1'b0;
      last_sat <= 1'b0;
    end else begin
      op_count <= next_op_count;
      last_ovf <= next_last_ovf;
      last_sat <= next_last_sat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus response: one wait state, and the answer stands for a single cycle

  always_comb begin
    next_pready  = access;
    next_pslverr = access & ~mapped;
    next_prdata  = halfword_mul_nmac_pkg::word_reset;
    if (access && mapped) begin
      if (!pwrite) begin
        next_prdata = rd_word;
      end else if (!write_ok) begin
        // busy or read-only target
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= halfword_mul_nmac_pkg::word_reset;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// >>> test/halfword_mul_nmac_properties.sv
// handshake checker for the halfword multiply unit's apb port
// assumes it is bound to the unit's top module and sees only its ports
`timescale 1ns/1ps
module halfword_mul_nmac_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic taken;
  logic mapped;
  assign taken  = psel && penable && !pready;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= 8'h18);
  // shadows of what software last wrote, and whether an operation may have moved them since
  logic [31:0] excp_shadow;
  logic [3:0]  cond_shadow;
  logic        excp_moved;
  logic        cond_moved;
  logic        wr_taken;
  logic        excp_rd;
  logic        cond_rd;
  assign wr_taken = taken && pwrite && mapped && paddr != halfword_mul_nmac_pkg::status_off;
  assign excp_rd  = pready && !pslverr && !pwrite && !excp_moved &&
                    paddr == halfword_mul_nmac_pkg::excp_off;
  assign cond_rd  = pready && !pslverr && !pwrite && !cond_moved &&
                    paddr == halfword_mul_nmac_pkg::cr_off;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excp_shadow <= 32'h0000_0000;
      cond_shadow <= 4'h0;
      excp_moved  <= 1'b0;
      cond_moved  <= 1'b0;
    end else begin
      if (wr_taken && paddr == halfword_mul_nmac_pkg::excp_off) begin
        excp_shadow <= pwdata;
        excp_moved  <= 1'b0;
      end
      if (wr_taken && paddr == halfword_mul_nmac_pkg::cr_off) begin
        cond_shadow <= pwdata[3:0];
        cond_moved  <= 1'b0;
      end
      // only an overflow-enabled nmac (kind bit 1 clear) may move the exception register
      if (wr_taken && paddr == halfword_mul_nmac_pkg::ctrl_off &&
          pwdata[halfword_mul_nmac_pkg::ctrl_oe_bit] && !pwdata[1]) begin
        excp_moved <= 1'b1;
      end
      if (wr_taken && paddr == halfword_mul_nmac_pkg::ctrl_off &&
          pwdata[halfword_mul_nmac_pkg::ctrl_record_bit]) begin
        cond_moved <= 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held");
  ready_after_access_a: assert property (taken |=> pready) else $error("no answer");
  ready_needs_access_a: assert property (pready |-> $past(taken)) else $error("stray pready");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero");
  status_write_err_a: assert property (taken && pwrite && paddr == 8'h18 |=> pslverr)
    else $error("status write accepted");
  unmapped_err_a: assert property (taken && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access accepted");
  mapped_read_ok_a: assert property (taken && !pwrite && mapped |=> !pslverr)
    else $error("mapped read refused");
  excp_kept_a: assert property (excp_rd |-> prdata == excp_shadow)
    else $error("exception register changed without overflow enable");
  cond_kept_a: assert property (cond_rd |-> prdata == {28'h000_0000, cond_shadow})
    else $error("condition field changed without record");
endmodule

bind halfword_mul_nmac_unit halfword_mul_nmac_properties halfword_mul_nmac_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> test/apb_host_model.sv
// apb master standing in for the decoder and register file side
// assumes the bench calls xfer from one process only
`timescale 1ns/1ps
module apb_host_model (
  input wire logic        pclk,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [7:0]  paddr,
  output logic     [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // request held until pready is seen at an edge; only the bench watchdog ends a dead wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the halfword multiply unit
// assumes the apb host model drives psel, penable, pwrite, paddr and pwdata of the unit; the bench drives pclk and presetn
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        e;
  int          errors;
  int          cmp_count;
  typedef struct {
    logic [3:0]  ctrl;
    logic [31:0] a, b, acc, res, excp_pre, excp_exp;
    logic [3:0]  cr_exp;
  } row_t;
  row_t rows [11];
  //////////////////////////////////////////////////////////////////////////////
  halfword_mul_nmac_unit halfword_mul_nmac_unit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  apb_host_model apb_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_model_i.xfer(1'b1, a, d, rd, e);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb_host_model_i.xfer(1'b0, a, 32'h0000_0000, rd, e);
    chk(n, rd, exp);
  endtask
  task automatic conclude;
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // ample for the rows plus the hand tests, which need well under a thousand cycles
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    // condition field preset to 4'ha before every row so an untouched field is visible
    rows = '{
      '{4'h0, 32'h1234_0003, 32'hffff_0004, 32'h0000_0010, 32'h0000_0004, 32'h4000_0000, 32'h4000_0000, 4'ha},
      '{4'h4, 32'h0000_ffff, 32'h0000_0002, 32'h7fff_ffff, 32'h8000_0001, 32'h0000_0000, 32'h0000_0000, 4'h8},
      '{4'h8, 32'h0000_ffff, 32'h0000_0002, 32'h7fff_ffff, 32'h8000_0001, 32'h0000_0000, 32'hc000_0000, 4'ha},
      '{4'hc, 32'h0000_0002, 32'h0000_0003, 32'h0000_0006, 32'h0000_0000, 32'hc000_0000, 32'h8000_0000, 4'h3},
      '{4'h1, 32'h0000_8000, 32'h0000_7fff, 32'h7fff_0000, 32'h7fff_ffff, 32'h4000_0000, 32'h4000_0000, 4'ha},
      '{4'hd, 32'h0000_7fff, 32'h0000_7fff, 32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 32'hc000_0000, 4'h9},
      '{4'h5, 32'h0000_0010, 32'h0000_0010, 32'h0000_0100, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 4'h3},
      '{4'ha, 32'haaaa_fffe, 32'h0003_5555, 32'h1234_5678, 32'hffff_fffa, 32'h4000_0000, 32'h4000_0000, 4'ha},
      '{4'h6, 32'h0000_8000, 32'h8000_0000, 32'h0000_0000, 32'h4000_0000, 32'h0000_0000, 32'h0000_0000, 4'h4},
      '{4'h3, 32'h0000_ffff, 32'hffff_0000, 32'h0000_0000, 32'hfffe_0001, 32'h0000_0000, 32'h0000_0000, 4'ha},
      '{4'h7, 32'h0000_ffff, 32'h0002_0000, 32'h0000_0000, 32'h0001_fffe, 32'h0000_0000, 32'h0000_0000, 4'h4}};
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("cond field at reset", 8'h14, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(halfword_mul_nmac_pkg::excp_off, rows[i].excp_pre);
      wr(halfword_mul_nmac_pkg::cr_off, 32'h0000_000a);
      wr(halfword_mul_nmac_pkg::src_a_off, rows[i].a);
      wr(halfword_mul_nmac_pkg::src_b_off, rows[i].b);
      wr(halfword_mul_nmac_pkg::acc_off, rows[i].acc);
      wr(halfword_mul_nmac_pkg::ctrl_off, {28'h000_0000, rows[i].ctrl});
      rdc("result", 8'h0c, rows[i].res);
      rdc("exception reg", 8'h10, rows[i].excp_exp);
      rdc("cond field", 8'h14, {28'h000_0000, rows[i].cr_exp});
    end
    // refused write must not disturb the operation count
    apb_host_model_i.xfer(1'b1, 8'h18, 32'hffff_ffff, rd, e);
    chk("status write refused", {31'h0000_0000, e}, 32'h0000_0001);
    apb_host_model_i.xfer(1'b0, 8'h1c, 32'h0000_0000, rd, e);
    chk("unmapped refused", {31'h0000_0000, e}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb_host_model_i.xfer(1'b0, 8'h18, 32'h0000_0000, rd, e);
    chk("op count", {24'h00_0000, rd[15:8]}, 32'h0000_000b);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("acc after reset", 8'h0c, 32'h0000_0000);
    rdc("status after reset", 8'h18, 32'h0000_0000);
    conclude();
  end
endmodule
